// *** core/psb_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psb_defs.svh"

module psb_port #(
  parameter int ADDR_W = `PSB_ADDR_W,
  parameter int LANES = `PSB_LANES,
  parameter int FIFO_DEPTH = `PSB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // command pins
  input wire logic clock_qualify_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic advance_load_n,
  input wire logic write_strobe_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic [ADDR_W-1:0] addr,
  // static and asynchronous controls
  input wire logic burst_interleave,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // data and parity lines
  input wire logic [LANES*`PSB_BYTE_W-1:0] dq_in,
  output logic [LANES*`PSB_BYTE_W-1:0] dq_out,
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [LANES-1:0] parity_lines_out,
  output logic dq_oe_n,
  // status
  output logic sleeping
);

  localparam int LANE_W = `PSB_LANE_W;
  localparam int WORD_W = LANES * LANE_W;

  // sleep entry and exit
  logic sleep_meta_reg;
  logic sleep_reg;

  // burst tracking
  psb_pkg::psb_burst_t bst_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [`PSB_BEAT_W-1:0] beat_reg;

  // pipeline
  logic rd_stage_reg;
  psb_pkg::psb_wcmd_t w1_reg;
  psb_pkg::psb_wcmd_t w2_reg;
  logic out_active_reg;
  logic [WORD_W-1:0] out_word_reg;

  // combinational
  logic adv;
  logic go;
  logic selected;
  logic [`PSB_BEAT_W-1:0] beat_next;
  psb_pkg::psb_issue_t issue;
  logic [WORD_W-1:0] mem_rd_data;
  logic [WORD_W-1:0] wr_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;

  function automatic logic [`PSB_BEAT_W-1:0] burst_seq(
    input logic [`PSB_BEAT_W-1:0] start,
    input logic [`PSB_BEAT_W-1:0] beat,
    input logic interleave
  );
    burst_seq = interleave ? (start ^ beat) : `PSB_BEAT_W'(start + beat);
  endfunction

  // a qualified edge: enabled, qualifier low and awake
  assign adv = clk_en && !clock_qualify_n && !sleep_reg;
  // a full read buffer holds off new commands
  assign go = adv && fifo_in_ready;
  assign selected = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign beat_next = `PSB_BEAT_W'(beat_reg + 1'b1);

  always_comb begin
    issue = '0;
    if (!advance_load_n) begin
      if (selected) begin
        issue.addr = addr;
        issue.rd = write_strobe_n;
        issue.wr = !write_strobe_n;
      end
    end else begin
      issue.addr = {base_reg[ADDR_W-1:`PSB_BEAT_W],
                    burst_seq(base_reg[`PSB_BEAT_W-1:0], beat_next, burst_interleave)};
      case (bst_reg)
        psb_pkg::BST_READ: begin
          issue.rd = 1'b1;
        end
        psb_pkg::BST_WRITE: begin
          issue.wr = 1'b1;
        end
        default: begin
          issue.rd = 1'b0;
        end
      endcase
    end
  end

  // two flops make the sleep level; entry and exit each take two edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end else if (clk_en) begin
      sleep_meta_reg <= sleep_request;
      sleep_reg <= sleep_meta_reg;
    end
  end

  // burst state and counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bst_reg <= psb_pkg::BST_IDLE;
      base_reg <= '0;
      beat_reg <= `PSB_BEAT_RST;
    end else if (clk_en && sleep_reg) begin
      bst_reg <= psb_pkg::BST_IDLE;
    end else if (go) begin
      if (!advance_load_n) begin
        beat_reg <= `PSB_BEAT_RST;
        if (selected) begin
          base_reg <= addr;
          bst_reg <= write_strobe_n ? psb_pkg::BST_READ : psb_pkg::BST_WRITE;
        end else begin
          bst_reg <= psb_pkg::BST_IDLE;
        end
      end else begin
        beat_reg <= beat_next;
      end
    end
  end

  // write pipeline: lane selects per beat, data two edges on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w1_reg <= '{valid: 1'b0, addr: '0, lane_n: `PSB_BW_RST};
      w2_reg <= '{valid: 1'b0, addr: '0, lane_n: `PSB_BW_RST};
    end else if (clk_en && sleep_reg) begin
      w1_reg.valid <= 1'b0;
      w2_reg.valid <= 1'b0;
    end else if (adv) begin
      w1_reg.valid <= go && issue.wr;
      w1_reg.addr <= issue.addr;
      w1_reg.lane_n <= byte_lane_write_n;
      w2_reg <= w1_reg;
    end
  end

  // read pipeline and output register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_stage_reg <= 1'b0;
      out_active_reg <= 1'b0;
    end else if (clk_en && sleep_reg) begin
      rd_stage_reg <= 1'b0;
      out_active_reg <= 1'b0;
    end else if (adv) begin
      rd_stage_reg <= go && issue.rd;
      // writes and deselects fall off the bus one edge later
      out_active_reg <= rd_stage_reg && fifo_out_valid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_word_reg <= '0;
    end else if (adv && rd_stage_reg && fifo_out_valid) begin
      out_word_reg <= fifo_out_data;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane_map
      assign wr_word[gi*LANE_W +: LANE_W] = {parity_lines_in[gi],
                                             dq_in[gi*`PSB_BYTE_W +: `PSB_BYTE_W]};
      assign dq_out[gi*`PSB_BYTE_W +: `PSB_BYTE_W] =
        out_word_reg[gi*LANE_W +: `PSB_BYTE_W];
      assign parity_lines_out[gi] = out_word_reg[gi*LANE_W + `PSB_BYTE_W];
    end
  endgenerate

  // output enable acts at once, without the clock
  assign dq_oe_n = !(out_active_reg && !output_enable_n && !sleep_reg);
  assign sleeping = sleep_reg;

  psb_mem #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .rd_en(go && issue.rd),
    .rd_addr(issue.addr),
    .rd_data(mem_rd_data),
    .wr_en(adv && w2_reg.valid),
    .wr_addr(w2_reg.addr),
    .wr_data(wr_word),
    .wr_lane_n(w2_reg.lane_n)
  );

  psb_fifo #(
    .W(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(adv && rd_stage_reg),
    .in_ready(fifo_in_ready),
    .in_data(mem_rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(adv),
    .out_data(fifo_out_data)
  );

endmodule

module psb_fifo #(
  parameter int W = `PSB_LANES * `PSB_LANE_W,
  parameter int DEPTH = `PSB_FIFO_DEPTH
) (
  // clock
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0] buf_mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic stored_any;
  logic push_store;
  logic pop_store;

  // empty fifo passes a word straight through when drained at once
  assign stored_any = (count_reg != '0);
  assign in_ready = (count_reg != FULL_CNT);
  assign out_valid = stored_any || in_valid;
  assign out_data = stored_any ? buf_mem[rd_ptr_reg] : in_data;
  assign push_store = in_valid && in_ready && !(!stored_any && out_ready);
  assign pop_store = out_ready && stored_any;

  always_ff @(posedge clk_sys) begin
    if (clk_en && push_store) begin
      buf_mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      if (push_store) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : PW'(wr_ptr_reg + 1'b1);
      end
      if (pop_store) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : PW'(rd_ptr_reg + 1'b1);
      end
      if (push_store && !pop_store) begin
        count_reg <= CW'(count_reg + 1'b1);
      end else if (pop_store && !push_store) begin
        count_reg <= CW'(count_reg - 1'b1);
      end
    end
  end

endmodule

`default_nettype wire

// *** core/psb_defs.svh ***
`ifndef PSB_DEFS_SVH
`define PSB_DEFS_SVH

// geometry
`define PSB_ADDR_W 19
`define PSB_LANES 4
`define PSB_LANE_W 9
`define PSB_BYTE_W 8
`define PSB_BEAT_W 2
`define PSB_FIFO_DEPTH 4

// reset values
`define PSB_BEAT_RST 2'h0
`define PSB_BW_RST 4'hF

// timing
`define PSB_CLK_PERIOD_NS 8
`define PSB_SLEEP_ENTRY_NS 16
`define PSB_SLEEP_RECOVERY_NS 16
`define PSB_SLEEP_ENTRY_CYC (`PSB_SLEEP_ENTRY_NS / `PSB_CLK_PERIOD_NS)
`define PSB_SLEEP_RECOVERY_CYC \
  ((`PSB_SLEEP_RECOVERY_NS + `PSB_CLK_PERIOD_NS - 1) / `PSB_CLK_PERIOD_NS)

`endif

// *** core/psb_pkg.sv ***
`include "psb_defs.svh"

package psb_pkg;

  typedef enum logic [1:0] {
    BST_IDLE,
    BST_READ,
    BST_WRITE
  } psb_burst_t;

  typedef struct packed {
    logic valid;
    logic [`PSB_ADDR_W-1:0] addr;
    logic [`PSB_LANES-1:0] lane_n;
  } psb_wcmd_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`PSB_ADDR_W-1:0] addr;
  } psb_issue_t;

endpackage

// *** core/psb_store.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psb_defs.svh"

module psb_mem #(
  parameter int ADDR_W = `PSB_ADDR_W,
  parameter int LANES = `PSB_LANES,
  parameter int LANE_W = `PSB_LANE_W
) (
  // clock
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // read port
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [LANES*LANE_W-1:0] rd_data,
  // write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LANES*LANE_W-1:0] wr_data,
  input wire logic [LANES-1:0] wr_lane_n
);

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [0:(1<<ADDR_W)-1];
      // only selected lanes change, parity bit included
      always_ff @(posedge clk_sys) begin
        if (clk_en && wr_en && !wr_lane_n[gi]) begin
          lane_mem[wr_addr] <= wr_data[gi*LANE_W +: LANE_W];
        end
      end
      // one register per lane keeps each slice to a single process
      logic [LANE_W-1:0] rd_lane_reg;
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          rd_lane_reg <= '0;
        end else if (clk_en && rd_en) begin
          rd_lane_reg <= lane_mem[rd_addr];
        end
      end
      assign rd_data[gi*LANE_W +: LANE_W] = rd_lane_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// *** sim/psb_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psb_defs.svh"

module psb_ctrl_model (
  // clock
  input wire logic clk_sys,
  // command pins
  output logic clock_qualify_n,
  output logic chip_select_1_n,
  output logic chip_select_2,
  output logic chip_select_3_n,
  output logic advance_load_n,
  output logic write_strobe_n,
  output logic [3:0] byte_lane_write_n,
  output logic [`PSB_ADDR_W-1:0] addr,
  // write data toward the device
  output logic [31:0] dq_in,
  output logic [3:0] parity_lines_in
);
  logic v0 = 1'b0;
  logic v1 = 1'b0;
  logic wb = 1'b0;
  logic [35:0] d0;
  logic [35:0] d1;

  initial begin
    {clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n} = 4'h5;
    {advance_load_n, write_strobe_n, byte_lane_write_n} = 6'h1F;
    addr = '0;
    {parity_lines_in, dq_in} = '0;
  end

  // one command per call; write data goes out two taken edges later
  task automatic issue(input logic q, l, w, s, input logic [3:0] b,
                       input logic [`PSB_ADDR_W-1:0] a, input logic [35:0] d);
    @(posedge clk_sys);
    clock_qualify_n <= q;
    advance_load_n <= l;
    write_strobe_n <= w;
    {chip_select_3_n, chip_select_2, chip_select_1_n} <= s ? 3'h2 : 3'h5;
    byte_lane_write_n <= b;
    addr <= a;
    {parity_lines_in, dq_in} <= v1 ? d1 : ~{parity_lines_in, dq_in};
    if (!q) begin
      wb = l ? wb : (s && !w);
      v1 = v0;
      d1 = d0;
      v0 = wb;
      d0 = d;
    end
  endtask
endmodule

`default_nettype wire

// *** sim/psb_port_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psb_defs.svh"

module psb_port_checker #(
  parameter int ADDR_W = `PSB_ADDR_W,
  parameter int LANES = `PSB_LANES,
  parameter int FIFO_DEPTH = `PSB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // command pins
  input wire logic clock_qualify_n,
  input wire logic chip_select_1_n,
  input wire logic chip_select_2,
  input wire logic chip_select_3_n,
  input wire logic advance_load_n,
  input wire logic write_strobe_n,
  input wire logic [LANES-1:0] byte_lane_write_n,
  input wire logic [ADDR_W-1:0] addr,
  // controls
  input wire logic burst_interleave,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  // data
  input wire logic [LANES*`PSB_BYTE_W-1:0] dq_in,
  input wire logic [LANES*`PSB_BYTE_W-1:0] dq_out,
  input wire logic [LANES-1:0] parity_lines_in,
  input wire logic [LANES-1:0] parity_lines_out,
  input wire logic dq_oe_n,
  input wire logic sleeping
);
  logic qual;
  logic ld;
  logic sel;
  assign qual = clk_en && !clock_qualify_n && !sleeping;
  assign ld = qual && !advance_load_n;
  assign sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_stall_holds: assert property ((!clk_en || clock_qualify_n) |=> $stable(dq_out))
    else $error("read data moved on an ignored edge");
  a_read_drives: assert property (
    ld && sel && write_strobe_n ##1 qual |=> output_enable_n || sleeping || !dq_oe_n)
    else $error("read data not driven");
  a_write_floats: assert property (ld && sel && !write_strobe_n ##1 qual |=> dq_oe_n)
    else $error("outputs driven in write data cycle");
  a_desel_floats: assert property (ld && !sel ##1 qual |=> dq_oe_n)
    else $error("outputs driven after deselect");
  a_oe_gates: assert property (output_enable_n |-> dq_oe_n)
    else $error("outputs driven with enable high");
  a_sleep_floats: assert property (sleeping |-> dq_oe_n)
    else $error("outputs driven while asleep");
  a_sleep_entry: assert property ((sleep_request && clk_en) [*2] |=> sleeping)
    else $error("sleep entry too slow");
  a_sleep_early: assert property (
    (!sleep_request && clk_en) [*2] ##1 sleep_request |=> !sleeping)
    else $error("sleep entry too fast");
  a_sleep_exit: assert property ((!sleep_request && clk_en) [*2] |=> !sleeping)
    else $error("sleep exit too slow");
  a_reset_float: assert property ($rose(rst_n) |-> dq_oe_n)
    else $error("outputs driven after reset");
endmodule

bind psb_port psb_port_checker #(.ADDR_W(ADDR_W), .LANES(LANES), .FIFO_DEPTH(FIFO_DEPTH))
  chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .clock_qualify_n(clock_qualify_n),
    .chip_select_1_n(chip_select_1_n), .chip_select_2(chip_select_2),
    .chip_select_3_n(chip_select_3_n), .advance_load_n(advance_load_n),
    .write_strobe_n(write_strobe_n), .byte_lane_write_n(byte_lane_write_n), .addr(addr),
    .burst_interleave(burst_interleave), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .parity_lines_in(parity_lines_in), .parity_lines_out(parity_lines_out),
    .dq_oe_n(dq_oe_n), .sleeping(sleeping)
  );

`default_nettype wire

// *** sim/psb_port_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psb_defs.svh"

module psb_port_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic burst_interleave = 1'b0;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic clock_qualify_n;
  logic chip_select_1_n;
  logic chip_select_2;
  logic chip_select_3_n;
  logic advance_load_n;
  logic write_strobe_n;
  logic [3:0] byte_lane_write_n;
  logic [`PSB_ADDR_W-1:0] addr;
  logic [31:0] dq_in;
  logic [31:0] dq_out;
  logic [3:0] parity_lines_in;
  logic [3:0] parity_lines_out;
  logic dq_oe_n;
  logic sleeping;
  int err_count = 0;
  int tests_run = 0;

  always #(`PSB_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  psb_ctrl_model m_u (
    .clk_sys(clk_sys), .clock_qualify_n(clock_qualify_n), .chip_select_1_n(chip_select_1_n),
    .chip_select_2(chip_select_2), .chip_select_3_n(chip_select_3_n),
    .advance_load_n(advance_load_n), .write_strobe_n(write_strobe_n),
    .byte_lane_write_n(byte_lane_write_n), .addr(addr), .dq_in(dq_in),
    .parity_lines_in(parity_lines_in)
  );
  psb_port dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .clock_qualify_n(clock_qualify_n),
    .chip_select_1_n(chip_select_1_n), .chip_select_2(chip_select_2),
    .chip_select_3_n(chip_select_3_n), .advance_load_n(advance_load_n),
    .write_strobe_n(write_strobe_n), .byte_lane_write_n(byte_lane_write_n), .addr(addr),
    .burst_interleave(burst_interleave), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .parity_lines_in(parity_lines_in), .parity_lines_out(parity_lines_out),
    .dq_oe_n(dq_oe_n), .sleeping(sleeping)
  );

  task automatic cmp_w(input string n, input logic [35:0] e, input logic [35:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic cmp_b(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %b got %b", n, e, s);
    end
  endtask

  task automatic results;
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [35:0] pat(input logic [1:0] k);
    return {4'hC ^ {2'h0, k}, 32'h1357_9BDF * {30'h0, k}};
  endfunction

  task automatic idle(input int n);
    repeat (n) m_u.issue(1'b0, 1'b0, 1'b1, 1'b0, 4'hF, '0, '0);
  endtask

  task automatic look(input logic [35:0] e, input logic oe);
    #1;
    cmp_w("read data", e, {parity_lines_out, dq_out});
    cmp_b("output float", oe, dq_oe_n);
  endtask

  task automatic wr(input logic [18:0] a, input logic [3:0] b, input logic [35:0] d);
    m_u.issue(1'b0, 1'b0, 1'b0, 1'b1, b, a, d);
    idle(2);
    #1;
    cmp_b("write float", 1'b1, dq_oe_n);
  endtask

  task automatic rd(input logic [18:0] a, input logic [35:0] e);
    m_u.issue(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, a, '0);
    idle(1);
    m_u.issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, '0, '0);
    look(e, 1'b0);
    m_u.issue(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, '0, '0);
    look(e, 1'b0);
    idle(2);
    look(e, 1'b1);
  endtask

  task automatic t_lanes;
    wr(19'h10, 4'h0, 36'hF_1122_3344);
    wr(19'h10, 4'hA, 36'h0_AABB_CCDD);
    wr(19'h10, 4'hF, 36'h5_5555_5555);
    rd(19'h10, 36'hA_11BB_33DD);
  endtask

  task automatic t_burst;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      burst_interleave <= m[0];
      for (int k = 0; k < 4; k++) begin
        m_u.issue(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, {17'h8, 2'(k)}, pat(2'(k)));
      end
      idle(2);
      m_u.issue(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 19'h21, '0);
      m_u.issue(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, '0, '0);
      for (int k = 0; k < 4; k++) begin
        m_u.issue(1'b0, 1'(k < 2), 1'b0, 1'b0, 4'h0, '0, '0);
        #1;
        cmp_w("burst beat", pat(m[0] ? 2'h1 ^ 2'(k) : 2'h1 + 2'(k)), {parity_lines_out, dq_out});
      end
    end
  endtask

  task automatic t_sleep;
    @(posedge clk_sys);
    output_enable_n <= 1'b1;
    sleep_request <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp_b("sleeping", 1'b1, sleeping);
    @(posedge clk_sys);
    sleep_request <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp_b("sleeping", 1'b0, sleeping);
    rd(19'h10, 36'hA_11BB_33DD);
  endtask

  // clock enable low freezes a pending read for one edge
  task automatic t_freeze;
    m_u.issue(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 19'h22, '0);
    m_u.issue(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 19'h10, '0);
    clk_en <= 1'b0;
    m_u.issue(1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 19'h10, '0);
    clk_en <= 1'b1;
    look(36'hA_11BB_33DD, 1'b1);
    idle(1);
    look(pat(2'h2), 1'b0);
    idle(1);
    look(36'hA_11BB_33DD, 1'b0);
    idle(1);
    look(36'hA_11BB_33DD, 1'b1);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    cmp_b("output float", 1'b1, dq_oe_n);
    t_lanes;
    t_burst;
    t_sleep;
    t_freeze;
    results;
  end

  initial begin
    repeat (1000) @(posedge clk_sys);
    err_count++;
    results;
  end
endmodule

`default_nettype wire
